// File: inc/scp_consts.svh
// Constants shared by both ends of the serial configuration port.
// Assumes inclusion by bare name from files under logic/.
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// ----------------------------------------------------------------
// Frame layout, counted in rising serial clock edges
// ----------------------------------------------------------------
`define SCP_ADDR_W        5
`define SCP_HDR_BITS      5'h08
`define SCP_RD_END        5'h0D
`define SCP_WR_END        5'h10
`define SCP_WR_LAST       5'h0F

// ----------------------------------------------------------------
// Device command register fields and reset value
// ----------------------------------------------------------------
`define SCP_CHAN_BASE     5'h04
`define SCP_FLD_FAMILY    3
`define SCP_FLD_EURO      2
`define SCP_FLD_LOCAL     1
`define SCP_FLD_REMOTE    0
`define SCP_CTRL_RST      4'h0

// ----------------------------------------------------------------
// Host register map on AXI4-Lite
// ----------------------------------------------------------------
`define SCP_CMD_OFF       8'h00
`define SCP_STAT_OFF      8'h04
`define SCP_RDAT_OFF      8'h08
`define SCP_CMD_RW_BIT    8
`define SCP_CMD_WD_LSB    16
`define SCP_STAT_BUSY     0
`define SCP_STAT_DONE     1
`define SCP_RESP_OKAY     2'h0
`define SCP_RESP_SLVERR   2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCP_ACLK_NS       5
`define SCP_CS_SETUP_NS   5
`define SCP_CS_SETUP_CYC  ((`SCP_CS_SETUP_NS + `SCP_ACLK_NS - 1) / `SCP_ACLK_NS)
`define SCP_SCLK_HALF_CYC 8

`endif

// File: inc/scp_pkg.sv
// Types shared by both ends of the serial configuration port.
// Assumes nothing beyond a SystemVerilog compiler.
package scp_pkg;

    // Line rate of one channel
    typedef enum logic [1:0] {
        SCP_RATE_DS3  = 2'h0,
        SCP_RATE_STS1 = 2'h1,
        SCP_RATE_E3   = 2'h2
    } scp_rate_e;

    // Loop-back mode of one channel
    typedef enum logic [1:0] {
        SCP_LOOP_NONE    = 2'h0,
        SCP_LOOP_ANALOG  = 2'h1,
        SCP_LOOP_DIGITAL = 2'h2,
        SCP_LOOP_REMOTE  = 2'h3
    } scp_loop_e;

    // Device frame decoder states
    typedef enum logic [4:0] {
        SCP_D_IDLE  = 5'h01,
        SCP_D_HEAD  = 5'h02,
        SCP_D_READ  = 5'h04,
        SCP_D_WRITE = 5'h08,
        SCP_D_DONE  = 5'h10
    } scp_dev_state_e;

    // Host frame generator states
    typedef enum logic [2:0] {
        SCP_H_IDLE  = 3'h1,
        SCP_H_WAIT  = 3'h2,
        SCP_H_SHIFT = 3'h4
    } scp_host_state_e;

endpackage

// File: inc/scp_if.sv
// Four-wire serial configuration link between host and device.
// Assumes the bench instantiates it and connects both modports.
interface scp_if;
    logic cs_n;
    logic sclk;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_out_oe;
    logic serial_data_line;

    // Released output reads as a pulled-up line
    assign serial_data_line = serial_data_out_oe ? serial_data_out : 1'b1;

    modport dev (
        input  cs_n,
        input  sclk,
        input  serial_data_in,
        output serial_data_out,
        output serial_data_out_oe
    );

    modport host (
        output cs_n,
        output sclk,
        output serial_data_in,
        input  serial_data_line
    );
endinterface

// File: logic/scp_device.sv
// Device end of the serial configuration port: frame decoder and
// per-channel rate and loop-back control registers.
// Assumes link pins are asynchronous to aclk and that the serial
// clock half period spans at least four aclk cycles.
// Function
// - Family bit 0 DS3, 1 STS-1
// - Family bit ignored while European bit set
// - European bit 1 selects E3 mode
// - Local/remote bits pick loop-back mode
// - Four wires: select, clock, data in, out
// - Host starts clock, then lowers select
// - Input bits captured on rising clock edges
// - First bit: 1 read, 0 write
// - Next five bits: address, LSB first
// - Read output enabled at falling edge eight
// - Five read bits LSB first, falling edges
// - Eight write bits LSB first from edge nine
// - Output released unless driving read data
// - Top register bit reserved, writes ignored
`include "scp_consts.svh"

module scp_device #(
    parameter int NCH = 3
) (
    // Clock, reset and enable
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          ce,
    // Serial link
    scp_if.dev                                 link,
    // Channel configuration
    output scp_pkg::scp_rate_e [NCH-1:0]       rate_mode,
    output scp_pkg::scp_loop_e [NCH-1:0]       loop_mode
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Channels must fit into the five-bit address space
    if (NCH < 1 || NCH > 28) begin : g_bad_nch
        $error("NCH out of range");
    end

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] cs_sync_r;
    logic [1:0] ck_sync_r;
    logic [1:0] di_sync_r;
    logic       ck_prev_r;
    logic       cs_act;
    logic       rise;
    logic       fall;
    logic       di;

    // Two flops per pin; only the second stage feeds logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_sync_r <= 2'h3;
            ck_sync_r <= 2'h0;
            di_sync_r <= 2'h0;
            ck_prev_r <= 1'b0;
        end else if (ce) begin
            cs_sync_r <= {cs_sync_r[0], link.cs_n};
            ck_sync_r <= {ck_sync_r[0], link.sclk};
            di_sync_r <= {di_sync_r[0], link.serial_data_in};
            ck_prev_r <= ck_sync_r[1];
        end
    end

    // Edges of the host clock as seen in the aclk domain
    assign cs_act = ~cs_sync_r[1];
    assign rise   = ce & cs_act & ck_sync_r[1] & ~ck_prev_r;
    assign fall   = ce & cs_act & ~ck_sync_r[1] & ck_prev_r;
    assign di     = di_sync_r[1];

    // ------------------------------------------------------------
    // Frame decoder
    // ------------------------------------------------------------
    scp_pkg::scp_dev_state_e state_r;
    logic [4:0]              cnt_r;
    logic                    rd_r;
    logic [4:0]              addr_r;
    logic [7:0]              wdat_r;
    logic                    commit;
    logic [7:0]              word;

    // Full data word including the bit arriving on this edge
    assign word   = {di, wdat_r[7:1]};
    assign commit = rise && state_r == scp_pkg::SCP_D_WRITE && cnt_r == `SCP_WR_LAST;

    // Bit counter and state; select going high drops the frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= scp_pkg::SCP_D_IDLE;
            cnt_r   <= 5'h00;
        end else if (ce) begin
            if (!cs_act) begin
                state_r <= scp_pkg::SCP_D_IDLE;
                cnt_r   <= 5'h00;
            end else begin
                unique case (state_r)
                    scp_pkg::SCP_D_IDLE: begin
                        state_r <= scp_pkg::SCP_D_HEAD;
                    end
                    scp_pkg::SCP_D_HEAD: begin
                        if (rise) begin
                            cnt_r <= cnt_r + 5'h01;
                            if (cnt_r == `SCP_HDR_BITS - 5'h01) begin
                                // Direction taken from the first bit
                                state_r <= rd_r ? scp_pkg::SCP_D_READ : scp_pkg::SCP_D_WRITE;
                            end
                        end
                    end
                    scp_pkg::SCP_D_READ: begin
                        if (rise) begin
                            cnt_r <= cnt_r + 5'h01;
                            if (cnt_r == `SCP_RD_END - 5'h01) begin
                                state_r <= scp_pkg::SCP_D_DONE;
                            end
                        end
                    end
                    scp_pkg::SCP_D_WRITE: begin
                        if (rise) begin
                            cnt_r <= cnt_r + 5'h01;
                            if (commit) begin
                                state_r <= scp_pkg::SCP_D_DONE;
                            end
                        end
                    end
                    scp_pkg::SCP_D_DONE: begin
                        // Extra clocks before select rises are ignored
                        state_r <= scp_pkg::SCP_D_DONE;
                    end
                endcase
            end
        end
    end

    // Header capture: direction bit, then address LSB first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_r   <= 1'b0;
            addr_r <= 5'h00;
        end else if (rise && state_r == scp_pkg::SCP_D_HEAD) begin
            if (cnt_r == 5'h00) begin
                rd_r <= di;
            end else if (cnt_r <= 5'h05) begin
                addr_r <= {di, addr_r[4:1]};
            end
            // Bits six and seven carry no information here
        end
    end

    // Write data shift register, LSB first from edge nine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdat_r <= 8'h00;
        end else if (rise && state_r == scp_pkg::SCP_D_WRITE) begin
            wdat_r <= word;
        end
    end

    // ------------------------------------------------------------
    // Channel command registers
    // ------------------------------------------------------------
    logic [3:0] ctrl_r [NCH];
    logic [4:0] rd_word;

    for (genvar i = 0; i < NCH; i++) begin : g_chan
        localparam logic [4:0] CH_ADDR = `SCP_CHAN_BASE + 5'(i);
        logic fam;
        logic eur;

        // Only a complete word to this address changes the register
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ctrl_r[i] <= `SCP_CTRL_RST;
            end else if (commit && addr_r == CH_ADDR) begin
                ctrl_r[i] <= word[3:0];
            end
        end

        assign fam = ctrl_r[i][`SCP_FLD_FAMILY];
        assign eur = ctrl_r[i][`SCP_FLD_EURO];

        // Registered mode outputs decoded from the command bits
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                rate_mode[i] <= scp_pkg::SCP_RATE_DS3;
                loop_mode[i] <= scp_pkg::SCP_LOOP_NONE;
            end else if (ce) begin
                if (eur) begin
                    rate_mode[i] <= scp_pkg::SCP_RATE_E3;
                end else if (fam) begin
                    rate_mode[i] <= scp_pkg::SCP_RATE_STS1;
                end else begin
                    rate_mode[i] <= scp_pkg::SCP_RATE_DS3;
                end
                unique case ({ctrl_r[i][`SCP_FLD_LOCAL], ctrl_r[i][`SCP_FLD_REMOTE]})
                    2'h0: loop_mode[i] <= scp_pkg::SCP_LOOP_NONE;
                    2'h2: loop_mode[i] <= scp_pkg::SCP_LOOP_ANALOG;
                    2'h3: loop_mode[i] <= scp_pkg::SCP_LOOP_DIGITAL;
                    2'h1: loop_mode[i] <= scp_pkg::SCP_LOOP_REMOTE;
                endcase
            end
        end
    end

    // Read word; reserved top bit and unmapped addresses read zero
    always_comb begin
        rd_word = 5'h00;
        for (int i = 0; i < NCH; i++) begin
            if (addr_r == `SCP_CHAN_BASE + 5'(i)) begin
                rd_word = {1'b0, ctrl_r[i]};
            end
        end
    end

    // ------------------------------------------------------------
    // Serial data output
    // ------------------------------------------------------------
    logic sdo_r;
    logic sdo_oe_r;

    // Drive only during the five read bits, changing on falling
    // edges so the host sees stable data at the next rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdo_r    <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (ce) begin
            if (!cs_act) begin
                sdo_oe_r <= 1'b0;
            end else if (fall) begin
                if (state_r == scp_pkg::SCP_D_READ && cnt_r < `SCP_RD_END) begin
                    sdo_oe_r <= 1'b1;
                    sdo_r    <= rd_word[cnt_r[2:0]];
                end else begin
                    sdo_oe_r <= 1'b0;
                end
            end
        end
    end

    assign link.serial_data_out    = sdo_r;
    assign link.serial_data_out_oe = sdo_oe_r;

endmodule

// File: logic/scp_host.sv
// Host end of the serial configuration port: AXI4-Lite command and
// status registers driving frames onto the four-wire link.
// Assumes one AXI4-Lite master with a single write and a single
// read outstanding at a time.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`include "scp_consts.svh"

module scp_host #(
    parameter int HALF_CYC = `SCP_SCLK_HALF_CYC
) (
    // Clock, reset and enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite write channels
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Serial link
    scp_if.host              link
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // The device needs four aclk cycles per half period to see edges
    if (HALF_CYC < 4 || HALF_CYC < `SCP_CS_SETUP_CYC || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC out of range");
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic [31:0] cmd_r;
    logic        done_r;
    logic [4:0]  rdat_r;
    logic        wr_fire;
    logic        busy;
    logic        start;
    scp_pkg::scp_host_state_e state_r;

    assign s_axi_awready = ce & ~aw_got_r & ~s_axi_bvalid;
    assign s_axi_wready  = ce & ~w_got_r & ~s_axi_bvalid;
    assign s_axi_arready = ce & ~s_axi_rvalid;
    assign wr_fire       = ce & aw_got_r & w_got_r;
    assign busy          = state_r != scp_pkg::SCP_H_IDLE;
    // A command written while a frame runs is acknowledged but neither stored nor started
    assign start         = wr_fire && awaddr_r == `SCP_CMD_OFF && !busy;

    // Address and data accepted in either order, answered together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            awaddr_r     <= 8'h00;
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SCP_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r == `SCP_CMD_OFF || awaddr_r == `SCP_STAT_OFF) ?
                                `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Command register with byte enables; frozen while busy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_r <= 32'h0000_0000;
        end else if (start) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_r[b]) begin
                    cmd_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
                end
            end
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SCP_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `SCP_RESP_OKAY;
                unique case (s_axi_araddr)
                    `SCP_CMD_OFF:  s_axi_rdata <= cmd_r;
                    `SCP_STAT_OFF: s_axi_rdata <= {30'h0000_0000, done_r, busy};
                    `SCP_RDAT_OFF: s_axi_rdata <= {27'h000_0000, rdat_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `SCP_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial clock divider
    // ------------------------------------------------------------
    logic [7:0] div_r;
    logic       sclk_r;
    logic       tick;
    logic       rise_ev;
    logic       fall_ev;

    assign tick    = ce && div_r == 8'(HALF_CYC - 1);
    assign rise_ev = tick & ~sclk_r;
    assign fall_ev = tick & sclk_r;

    // Free running so the clock is up before any frame starts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r  <= 8'h00;
            sclk_r <= 1'b0;
        end else if (ce) begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            if (tick) begin
                sclk_r <= ~sclk_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Frame generator
    // ------------------------------------------------------------
    logic [1:0]  sdo_sync_r;
    logic [4:0]  bcnt_r;
    logic        cs_n_r;
    logic        sdi_r;
    logic [15:0] frame;
    logic        rd;
    logic [4:0]  last;

    assign rd    = cmd_r[`SCP_CMD_RW_BIT];
    assign frame = {cmd_r[`SCP_CMD_WD_LSB +: 8], 2'h0, cmd_r[4:0], rd};
    assign last  = rd ? `SCP_RD_END : `SCP_WR_END;

    // Returning data line, two flops before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdo_sync_r <= 2'h3;
        end else if (ce) begin
            sdo_sync_r <= {sdo_sync_r[0], link.serial_data_line};
        end
    end

    // Select falls and bits change on falling edges of the clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= scp_pkg::SCP_H_IDLE;
            bcnt_r  <= 5'h00;
            cs_n_r  <= 1'b1;
            sdi_r   <= 1'b0;
            rdat_r  <= 5'h00;
        end else if (ce) begin
            unique case (state_r)
                scp_pkg::SCP_H_IDLE: begin
                    if (start) begin
                        state_r <= scp_pkg::SCP_H_WAIT;
                    end
                end
                scp_pkg::SCP_H_WAIT: begin
                    if (fall_ev) begin
                        state_r <= scp_pkg::SCP_H_SHIFT;
                        cs_n_r  <= 1'b0;
                        sdi_r   <= frame[0];
                        bcnt_r  <= 5'h00;
                    end
                end
                scp_pkg::SCP_H_SHIFT: begin
                    if (rise_ev) begin
                        bcnt_r <= bcnt_r + 5'h01;
                        if (rd && bcnt_r >= `SCP_HDR_BITS && bcnt_r < `SCP_RD_END) begin
                            rdat_r <= {sdo_sync_r[1], rdat_r[4:1]};
                        end
                    end else if (fall_ev) begin
                        if (bcnt_r == last) begin
                            state_r <= scp_pkg::SCP_H_IDLE;
                            cs_n_r  <= 1'b1;
                            sdi_r   <= 1'b0;
                        end else begin
                            sdi_r <= frame[bcnt_r[3:0]];
                        end
                    end
                end
            endcase
        end
    end

    // Done is sticky; a finishing frame beats a clear in one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_r <= 1'b0;
        end else if (ce) begin
            if (state_r == scp_pkg::SCP_H_SHIFT && fall_ev && bcnt_r == last) begin
                done_r <= 1'b1;
            end else if (wr_fire && awaddr_r == `SCP_STAT_OFF && wstrb_r[0] &&
                         wdata_r[`SCP_STAT_DONE]) begin
                done_r <= 1'b0;
            end
        end
    end

    assign link.cs_n           = cs_n_r;
    assign link.sclk           = sclk_r;
    assign link.serial_data_in = sdi_r;

endmodule

// File: sim/scp_assertions.sv
// Link checker: watches the four configuration wires.
// Assumes the bench wires it beside the link interface.
module scp_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // Link properties
    // ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Sync delay lets oe lag cs_n by a few cycles, not more
    oe_released_a: assert property (cs_n [*5] |-> !serial_data_out_oe)
        else $error("out driven outside frame");
    oe_enable_a: assert property ($rose(serial_data_out_oe) |-> !cs_n && !sclk)
        else $error("oe rose off a falling edge");
    oe_hold_a: assert property ($rose(serial_data_out_oe) |-> serial_data_out_oe [*8])
        else $error("read bit cut short");
    out_on_fall_a: assert property ($changed(serial_data_out) && serial_data_out_oe &&
        $past(serial_data_out_oe) |-> !sclk) else $error("out moved with sclk high");
    sdi_stable_a: assert property (sclk && $past(sclk) && !cs_n |-> $stable(serial_data_in))
        else $error("data in moved with sclk high");
    cs_fall_a: assert property ($fell(cs_n) |-> !sclk)
        else $error("select fell with sclk high");
    cs_rise_a: assert property ($rose(cs_n) |-> !sclk)
        else $error("select rose with sclk high");
    clk_runs_a: assert property (!cs_n |-> ##[1:8] $changed(sclk))
        else $error("sclk stalled in frame");
    // Main scenarios
    cover property ($rose(serial_data_out_oe));
    cover property ($fell(cs_n));
    cover property ($rose(cs_n) ##1 cs_n);
endmodule

// File: sim/serial_config_port_mode_loop_test.sv
// Bench: host and device ends joined over the link.
// Assumes the package, interface and design are compiled first.
module serial_config_port_mode_loop_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic        ce = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, q;
    logic [1:0]  b;
    scp_pkg::scp_rate_e [2:0] rate_mode;
    scp_pkg::scp_loop_e [2:0] loop_mode;
    int          fails = 0;
    int          n_checks = 0;
    scp_if lk ();
    scp_host u_scp_host (.*, .link(lk.host));
    scp_device u_scp_device (.*, .link(lk.dev));
    scp_assertions u_scp_assertions (.aclk(aclk), .aresetn(aresetn), .cs_n(lk.cs_n), .sclk(lk.sclk),
        .serial_data_in(lk.serial_data_in), .serial_data_out(lk.serial_data_out),
        .serial_data_out_oe(lk.serial_data_out_oe));
    always #2.5 aclk = ~aclk;
    // ----------------
    // Bus and judging
    // ----------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Write channels are released one by one as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        b = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        q = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask
    // Polling done costs a few reads but needs no frame-length guess
    task automatic frame(input logic rw, input logic [4:0] a, input logic [7:0] d);
        wr(8'h00, {8'h00, d, 7'h00, rw, 3'h0, a});
        do rd(8'h04); while (q[1] !== 1'h1);
        wr(8'h04, 32'h0000_0002);
    endtask
    // ----------------
    // Scenarios
    // ----------------
    // Every mode code, channels rotating, ignored data bits set
    task automatic t_modes();
        logic [3:0] d;
        for (int i = 0; i < 16; i++) begin
            d = i[3:0];
            frame(1'h0, 5'h04 + 5'(i % 3), {4'hf, d});
            if (!d[2]) chk(rate_mode[i % 3], {1'h0, d[3]});
            else chk(rate_mode[i % 3], 2'h2);
            chk(loop_mode[i % 3], d[0] ? (d[1] ? 2'h2 : 2'h3) : {1'h0, d[1]});
            frame(1'h1, 5'h04 + 5'(i % 3), 8'h00);
            rd(8'h08);
            chk(q, {28'h000_0000, d});
            chk(lk.serial_data_line, 1'h1);
        end
    endtask
    // Unmapped places on both sides
    task automatic t_unmapped();
        frame(1'h1, 5'h1f, 8'h00);
        rd(8'h08);
        chk(q, 32'h0000_0000);
        rd(8'h0c);
        chk(s_axi_rresp, 2'h2);
        wr(8'h0c, 32'h0000_0000);
        chk(b, 2'h2);
        // Address just past the last channel must not alias onto it
        frame(1'h0, 5'h07, 8'h00);
        frame(1'h1, 5'h06, 8'h00);
        rd(8'h08);
        chk(q, 32'h0000_000e);
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_modes();
        t_unmapped();
        conclude();
    end
    // Watchdog well past the expected run
    initial begin
        #400000;
        fails++;
        conclude();
    end
endmodule
